// ---- verilog/pcip_pkg.sv ----
`default_nettype none

// ****************************************************************
// Constants shared by the register bank and the power-mode machine
// ****************************************************************
package pcip_pkg;

    // ************************************************************
    // Configuration-space offsets (byte addresses, dword aligned)
    // ************************************************************
    localparam logic [7:0] INTLAT_OFFSET  = 8'h3c; // Interrupt/latency
    localparam logic [7:0] DRVPWR_OFFSET  = 8'h40; // Driver area/power

    // ************************************************************
    // Interrupt/latency register fields
    // ************************************************************
    localparam int         MAX_LAT_LSB    = 24;    // Bits 31:24
    localparam int         MIN_GNT_LSB    = 16;    // Bits 23:16
    localparam int         INT_PIN_LSB    = 8;     // Bits 15:8
    localparam int         INT_LINE_LSB   = 0;     // Bits 7:0
    localparam logic [7:0] MAX_LAT_RESET  = 8'h28; // Quarter-us units
    localparam logic [7:0] MIN_GNT_RESET  = 8'h14; // Quarter-us units
    localparam logic [7:0] INT_PIN_VALUE  = 8'h01; // First pin, fixed
    localparam logic [7:0] INT_LINE_RESET = 8'h00; // Undefined, zeroed

    // ************************************************************
    // Driver area/power register fields
    // ************************************************************
    localparam int         SLEEP_BIT      = 31;
    localparam int         SNOOZE_BIT     = 30;
    localparam int         DRV_BYTE_LSB   = 8;     // Bits 15:8
    localparam logic [7:0] DRV_BYTE_RESET = 8'h00; // Undefined, zeroed
    localparam logic       MODE_RESET     = 1'b0;  // Sleep/snooze off

    // ************************************************************
    // Power-mode timing
    // ************************************************************
    // Idle cycles held after activity; snooze gates clocks again on the next idle cycle after these
    localparam int         WAKE_HOLD_CYCLES = 4;

    // ************************************************************
    // Power-mode states
    // ************************************************************
    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00, // Normal operation
        PWR_SLEEP = 2'b01, // Clocks gated, config space only
        PWR_DOZE  = 2'b10, // Snooze, clocks gated
        PWR_WAKE  = 2'b11  // Snooze, temporarily awake
    } pcip_pwr_state_t;

endpackage : pcip_pkg

`default_nettype wire

// ---- verilog/pcip_power_fsm.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Sleep / snooze power-mode machine
// ****************************************************************
module pcip_power_fsm #(
    parameter int HOLD_CYCLES = pcip_pkg::WAKE_HOLD_CYCLES
) (
    input  wire logic                      ref_clk_i,    // Bus clock
    input  wire logic                      reset_i,      // Sync, high
    input  wire logic                      sleep_en_i,   // Sleep bit
    input  wire logic                      snooze_en_i,  // Snooze bit
    input  wire logic                      activity_i,   // Any wake cause
    output var  logic                      clk_gate_o,   // Gate request
    output var  logic                      csr_block_o,  // CSRs closed
    output var  pcip_pkg::pcip_pwr_state_t state_o       // Current mode
);

    // Hold counter wide enough for the idle delay
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    // All state in one record
    typedef struct packed {
        pcip_pkg::pcip_pwr_state_t st;    // Mode
        logic [CW-1:0]             hold;  // Idle cycles left
        logic                      gate;  // Registered gate request
        logic                      block; // Registered CSR block
    } pcip_fsm_t;

    pcip_fsm_t s_q;  // Current
    pcip_fsm_t s_d;  // Next

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        s_d = s_q;
        if (sleep_en_i) begin
            // Sleep wins if software sets both bits by mistake
            s_d.st = pcip_pkg::PWR_SLEEP;
        end else if (snooze_en_i) begin
            case (s_q.st)
                pcip_pkg::PWR_WAKE: begin
                    if (activity_i) begin
                        s_d.hold = CW'(HOLD_CYCLES);
                    end else if (s_q.hold == '0) begin
                        s_d.st = pcip_pkg::PWR_DOZE;
                    end else begin
                        s_d.hold = s_q.hold - CW'(1);
                    end
                end
                default: begin
                    // Activity wakes at once; otherwise doze
                    if (activity_i) begin
                        s_d.st   = pcip_pkg::PWR_WAKE;
                        s_d.hold = CW'(HOLD_CYCLES);
                    end else begin
                        s_d.st = pcip_pkg::PWR_DOZE;
                    end
                end
            endcase
        end else begin
            // Clearing both bits returns to run, held while both bits stay clear
            s_d.st = pcip_pkg::PWR_RUN;
        end
        s_d.gate  = (s_d.st == pcip_pkg::PWR_SLEEP) ||
                    (s_d.st == pcip_pkg::PWR_DOZE);
        s_d.block = (s_d.st == pcip_pkg::PWR_SLEEP);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            // Hardware reset always leaves sleep
            s_q <= '{pcip_pkg::PWR_RUN, '0, 1'b0, 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_gate_o  = s_q.gate;
    assign csr_block_o = s_q.block;
    assign state_o     = s_q.st;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_sleep_enter;
        @(posedge ref_clk_i) disable iff (reset_i)
        sleep_en_i |=> (state_o == pcip_pkg::PWR_SLEEP) && clk_gate_o
                       && csr_block_o;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep bit did not gate clocks");

    property p_reset_exit;
        @(posedge ref_clk_i)
        reset_i |=> (state_o == pcip_pkg::PWR_RUN) && !clk_gate_o;
    endproperty
    a_reset_exit: assert property (p_reset_exit)
        else $error("reset did not leave power mode");

    property p_clear_exit;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!sleep_en_i && !snooze_en_i) [*2] |->
            (state_o == pcip_pkg::PWR_RUN) && !clk_gate_o && !csr_block_o;
    endproperty
    a_clear_exit: assert property (p_clear_exit)
        else $error("cleared bits did not end power mode");

    property p_snooze_wake;
        @(posedge ref_clk_i) disable iff (reset_i)
        snooze_en_i && !sleep_en_i && activity_i |=>
            (state_o == pcip_pkg::PWR_WAKE) && !clk_gate_o;
    endproperty
    a_snooze_wake: assert property (p_snooze_wake)
        else $error("snooze did not wake on activity");

    property p_snooze_regate;
        @(posedge ref_clk_i) disable iff (reset_i)
        (snooze_en_i && !sleep_en_i && !activity_i) [*7] |->
            clk_gate_o && (state_o == pcip_pkg::PWR_DOZE);
    endproperty
    a_snooze_regate: assert property (p_snooze_regate)
        else $error("snooze did not re-gate after idle");

    c_wake: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        state_o == pcip_pkg::PWR_DOZE ##1 state_o == pcip_pkg::PWR_WAKE);
    c_sleep: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        state_o == pcip_pkg::PWR_SLEEP ##1 state_o == pcip_pkg::PWR_RUN);

endmodule : pcip_power_fsm

`default_nettype wire

// ---- verilog/pcip_regs.sv ----
// Summary of operation
// - Bits 31:24 report bus-access interval
// - Bits 23:16 report needed burst length
// - Interrupt pin byte always reads 01
// - Interrupt line byte stored, read back only
// - Sleep bit gates clocks, config space only
// - Reset or clearing the bit ends sleep
// - Snooze gates; activity wakes; idle re-gates
// - Driver byte 15:8 freely read and written
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Interrupt/latency and driver-area/power configuration registers
// ****************************************************************
module pcip_regs #(
    parameter logic [7:0] MAX_LAT     = pcip_pkg::MAX_LAT_RESET,
    parameter logic [7:0] MIN_GNT     = pcip_pkg::MIN_GNT_RESET,
    parameter int         HOLD_CYCLES = pcip_pkg::WAKE_HOLD_CYCLES
) (
    input  wire logic                      ref_clk_i,          // Bus clk
    input  wire logic                      reset_i,            // Sync
    input  wire logic                      cfg_req_i,          // Access
    input  wire logic                      cfg_we_i,           // 1=write
    input  wire logic [7:0]                cfg_addr_i,         // Byte adr
    input  wire logic [3:0]                cfg_be_i,           // Lanes
    input  wire logic [31:0]               cfg_wdata_i,        // Wr data
    input  wire logic                      net_activity_i,     // Line
    input  wire logic                      tx_start_i,         // Tx go
    input  wire logic                      csr_access_i,       // Host CSR
    output var  logic [31:0]               cfg_rdata_o,        // Rd data
    output var  logic                      cfg_ack_o,          // Done
    output var  logic                      clk_gate_o,         // Gate req
    output var  logic                      csr_access_block_o, // Sleep
    output var  pcip_pkg::pcip_pwr_state_t power_state_o       // Mode
);

    // ************************************************************
    // State record
    // ************************************************************
    typedef struct packed {
        logic [7:0]  int_line; // Interrupt routing byte
        logic [7:0]  drv_byte; // Driver scratch byte
        logic        sleep;    // Sleep request bit
        logic        snooze;   // Snooze request bit
        logic [31:0] rdata;    // Registered read data
        logic        ack;      // One-cycle completion
    } pcip_regs_t;

    pcip_regs_t r_q;  // Current
    pcip_regs_t r_d;  // Next

    logic        hit_intlat;  // Address selects interrupt register
    logic        hit_drvpwr;  // Address selects driver-area register
    logic [31:0] intlat_val;  // Read view of interrupt register
    logic [31:0] drvpwr_val;  // Read view of driver-area register
    logic        activity;    // Any cause that wakes from snooze

    // ************************************************************
    // Decode and read views
    // ************************************************************
    always_comb begin
        // Low two address bits are ignored: dword registers
        hit_intlat = cfg_addr_i[7:2] == pcip_pkg::INTLAT_OFFSET[7:2];
        hit_drvpwr = cfg_addr_i[7:2] == pcip_pkg::DRVPWR_OFFSET[7:2];
        intlat_val = '0;
        intlat_val[pcip_pkg::MAX_LAT_LSB +: 8]  = MAX_LAT;
        intlat_val[pcip_pkg::MIN_GNT_LSB +: 8]  = MIN_GNT;
        intlat_val[pcip_pkg::INT_PIN_LSB +: 8]  =
            pcip_pkg::INT_PIN_VALUE;
        intlat_val[pcip_pkg::INT_LINE_LSB +: 8] = r_q.int_line;
        // Everything not named below stays zero
        drvpwr_val = '0;
        drvpwr_val[pcip_pkg::SLEEP_BIT]          = r_q.sleep;
        drvpwr_val[pcip_pkg::SNOOZE_BIT]         = r_q.snooze;
        drvpwr_val[pcip_pkg::DRV_BYTE_LSB +: 8]  = r_q.drv_byte;
    end

    // A config access also counts as host activity for snooze
    assign activity = net_activity_i || tx_start_i || csr_access_i ||
                      cfg_req_i;

    // ************************************************************
    // Register next values
    // ************************************************************
    always_comb begin
        r_d     = r_q;
        r_d.ack = cfg_req_i;
        if (cfg_req_i && cfg_we_i) begin
            // Config space stays writable in every power mode
            if (hit_intlat && cfg_be_i[0]) begin
                r_d.int_line = cfg_wdata_i[7:0];
            end
            if (hit_drvpwr && cfg_be_i[1]) begin
                r_d.drv_byte = cfg_wdata_i[15:8];
            end
            if (hit_drvpwr && cfg_be_i[3]) begin
                // Both bits stored as written; the machine gives sleep
                // priority should software break the pairing
                r_d.sleep  = cfg_wdata_i[pcip_pkg::SLEEP_BIT];
                r_d.snooze = cfg_wdata_i[pcip_pkg::SNOOZE_BIT];
            end
        end else if (cfg_req_i) begin
            // Reads return the value before this cycle
            if (hit_intlat) begin
                r_d.rdata = intlat_val;
            end else if (hit_drvpwr) begin
                r_d.rdata = drvpwr_val;
            end else begin
                // Offsets outside this bank answer with zero
                r_d.rdata = '0;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            r_q <= '{pcip_pkg::INT_LINE_RESET, pcip_pkg::DRV_BYTE_RESET,
                     pcip_pkg::MODE_RESET, pcip_pkg::MODE_RESET,
                     32'h0000_0000, 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign cfg_rdata_o = r_q.rdata;
    assign cfg_ack_o   = r_q.ack;

    // ************************************************************
    // Power-mode machine
    // ************************************************************
    pcip_power_fsm #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_power (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .sleep_en_i  (r_q.sleep),
        .snooze_en_i (r_q.snooze),
        .activity_i  (activity),
        .clk_gate_o  (clk_gate_o),
        .csr_block_o (csr_access_block_o),
        .state_o     (power_state_o)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_rd_intlat;
        cfg_req_i && !cfg_we_i && hit_intlat;
    endsequence

    sequence s_rd_drvpwr;
        cfg_req_i && !cfg_we_i && hit_drvpwr;
    endsequence

    property p_max_lat;
        @(posedge ref_clk_i) disable iff (reset_i)
        s_rd_intlat |=> cfg_ack_o && (cfg_rdata_o[31:24] == MAX_LAT);
    endproperty
    a_max_lat: assert property (p_max_lat)
        else $error("max latency field wrong");

    property p_min_gnt;
        @(posedge ref_clk_i) disable iff (reset_i)
        s_rd_intlat |=> cfg_rdata_o[23:16] == MIN_GNT;
    endproperty
    a_min_gnt: assert property (p_min_gnt)
        else $error("min grant field wrong");

    property p_int_pin;
        @(posedge ref_clk_i) disable iff (reset_i)
        s_rd_intlat |=> cfg_rdata_o[15:8] == 8'h01;
    endproperty
    a_int_pin: assert property (p_int_pin)
        else $error("interrupt pin byte not 01");

    property p_int_line;
        @(posedge ref_clk_i) disable iff (reset_i)
        cfg_req_i && cfg_we_i && hit_intlat && cfg_be_i[0] ##1 s_rd_intlat
            |=> cfg_rdata_o[7:0] == $past(cfg_wdata_i[7:0], 2);
    endproperty
    a_int_line: assert property (p_int_line)
        else $error("interrupt line not read back");

    property p_drv_byte;
        @(posedge ref_clk_i) disable iff (reset_i)
        cfg_req_i && cfg_we_i && hit_drvpwr && cfg_be_i[1] ##1 s_rd_drvpwr
            |=> cfg_rdata_o[15:8] == $past(cfg_wdata_i[15:8], 2);
    endproperty
    a_drv_byte: assert property (p_drv_byte)
        else $error("driver byte not read back");

    property p_rsvd_zero;
        @(posedge ref_clk_i) disable iff (reset_i)
        s_rd_drvpwr |=> (cfg_rdata_o[29:16] == 14'h0000) &&
                        (cfg_rdata_o[7:0] == 8'h00);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("undefined bits not zero");

    property p_sleep_write;
        @(posedge ref_clk_i) disable iff (reset_i)
        cfg_req_i && cfg_we_i && hit_drvpwr && cfg_be_i[3] &&
        cfg_wdata_i[31] |-> ##2 clk_gate_o && csr_access_block_o;
    endproperty
    a_sleep_write: assert property (p_sleep_write)
        else $error("sleep write did not gate within two cycles");

    property p_ack;
        @(posedge ref_clk_i) disable iff (reset_i)
        cfg_req_i |=> cfg_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("access not acknowledged next cycle");

    c_rd_intlat: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        s_rd_intlat);
    c_snooze: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        r_q.snooze && clk_gate_o ##1 !clk_gate_o);
    c_drv_rw: cover property (@(posedge ref_clk_i) disable iff (reset_i)
        cfg_req_i && cfg_we_i && hit_drvpwr ##1 s_rd_drvpwr);

endmodule : pcip_regs

`default_nettype wire

// ---- tb/pcip_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Self-checking bench for the config registers and power modes
// ****************************************************************
module pcip_regs_tb;

    logic        ref_clk_i;      // 25 MHz bus clock
    logic        reset_i;        // Synchronous, active high
    logic        cfg_req_i;      // One-cycle access request
    logic        cfg_we_i;       // 1 = write
    logic [7:0]  cfg_addr_i;     // Byte address
    logic [3:0]  cfg_be_i;       // Byte lanes
    logic [31:0] cfg_wdata_i;    // Write data
    logic        net_activity_i; // Wake source: line
    logic        tx_start_i;     // Wake source: transmit
    logic        csr_access_i;   // Wake source: host CSR
    logic [31:0] cfg_rdata_o;    // Read data
    logic        cfg_ack_o;      // Access done pulse
    logic        clk_gate_o;     // Gate request
    logic        csr_access_block_o; // Sleep blocks CSRs
    pcip_pkg::pcip_pwr_state_t power_state_o; // Current mode
    logic [31:0] rd_val;         // Last value read back
    int          failures;       // Mismatch count
    int          cmp_count;      // Comparison count

    // Device under test with its documented defaults
    pcip_regs i_pcip_regs (
        .ref_clk_i          (ref_clk_i),
        .reset_i            (reset_i),
        .cfg_req_i          (cfg_req_i),
        .cfg_we_i           (cfg_we_i),
        .cfg_addr_i         (cfg_addr_i),
        .cfg_be_i           (cfg_be_i),
        .cfg_wdata_i        (cfg_wdata_i),
        .net_activity_i     (net_activity_i),
        .tx_start_i         (tx_start_i),
        .csr_access_i       (csr_access_i),
        .cfg_rdata_o        (cfg_rdata_o),
        .cfg_ack_o          (cfg_ack_o),
        .clk_gate_o         (clk_gate_o),
        .csr_access_block_o (csr_access_block_o),
        .power_state_o      (power_state_o)
    );

    // ************************************************************
    // Clock and shared tasks
    // ************************************************************
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Compare and count; report a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One access: request for one cycle, ack sampled the cycle after
    task automatic cfg_access(input logic we, input logic [7:0] addr,
                              input logic [3:0] be, input logic [31:0] wd);
        @(negedge ref_clk_i);
        cfg_req_i   = 1'b1;
        cfg_we_i    = we;
        cfg_addr_i  = addr;
        cfg_be_i    = be;
        cfg_wdata_i = wd;
        @(negedge ref_clk_i);
        cfg_req_i = 1'b0;
        check({31'h0, cfg_ack_o}, 32'h1);
        if (!we) begin
            rd_val = cfg_rdata_o;
        end
    endtask : cfg_access

    // Write, then read back at the very next edge with no idle gap,
    // so the write-then-read checks in the design see their case
    task automatic wr_rd(input logic [7:0] addr, input logic [3:0] be,
                         input logic [31:0] wd, input logic [31:0] exp);
        @(negedge ref_clk_i);
        cfg_req_i   = 1'b1;
        cfg_we_i    = 1'b1;
        cfg_addr_i  = addr;
        cfg_be_i    = be;
        cfg_wdata_i = wd;
        @(negedge ref_clk_i);
        check({31'h0, cfg_ack_o}, 32'h1);
        // Request stays up: the read is taken at the next edge
        cfg_we_i    = 1'b0;
        cfg_be_i    = 4'h0;
        cfg_wdata_i = 32'h0;
        @(negedge ref_clk_i);
        cfg_req_i = 1'b0;
        check({31'h0, cfg_ack_o}, 32'h1);
        check(cfg_rdata_o, exp);
    endtask : wr_rd

    // Read and compare in one call
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        cfg_access(1'b0, addr, 4'h0, 32'h0);
        check(rd_val, exp);
    endtask : rd_chk

    // Compare mode, gate and block outputs together
    task automatic pwr_chk(input pcip_pkg::pcip_pwr_state_t st,
                           input logic gate, input logic blk);
        check({28'h0, power_state_o, clk_gate_o, csr_access_block_o},
              {28'h0, st, gate, blk});
    endtask : pwr_chk

    // Print counts and verdict, then stop
    task automatic summarize();
        $display("comparisons=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // Watchdog: the sequence needs well under 400 cycles
    initial begin
        #(40 * 3000);
        failures++;
        summarize();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        failures = 0;
        cmp_count = 0;
        reset_i = 1'b1;
        cfg_req_i = 1'b0;
        cfg_we_i = 1'b0;
        cfg_addr_i = 8'h00;
        cfg_be_i = 4'h0;
        cfg_wdata_i = 32'h0;
        {csr_access_i, tx_start_i, net_activity_i} = 3'b000;
        repeat (6) @(negedge ref_clk_i);
        reset_i = 1'b0;
        pwr_chk(pcip_pkg::PWR_RUN, 1'b0, 1'b0);
        // Latency fields and fixed pin code after reset
        rd_chk(8'h3c, 32'h2814_0100);
        // Read-only fields ignore an all-ones write
        cfg_access(1'b1, 8'h3c, 4'hf, 32'hffff_ffff);
        rd_chk(8'h3c, 32'h2814_01ff);
        // Disabled lanes leave the line byte alone
        cfg_access(1'b1, 8'h3c, 4'he, 32'h0000_0000);
        rd_chk(8'h3c, 32'h2814_01ff);
        wr_rd(8'h3c, 4'h1, 32'h0000_00a5, 32'h2814_01a5);
        pwr_chk(pcip_pkg::PWR_RUN, 1'b0, 1'b0);
        // Driver byte, undefined bits zero, modes left off
        cfg_access(1'b1, 8'h40, 4'hf, 32'h3fff_ffff);
        rd_chk(8'h40, 32'h0000_ff00);
        wr_rd(8'h40, 4'h2, 32'h0000_5a00, 32'h0000_5a00);
        // Unmapped offset reads zero
        rd_chk(8'h44, 32'h0000_0000);
        // Sleep: gated, CSRs blocked, config space still answers
        cfg_access(1'b1, 8'h40, 4'h8, 32'h8000_0000);
        @(negedge ref_clk_i);
        pwr_chk(pcip_pkg::PWR_SLEEP, 1'b1, 1'b1);
        net_activity_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        pwr_chk(pcip_pkg::PWR_SLEEP, 1'b1, 1'b1);
        net_activity_i = 1'b0;
        rd_chk(8'h40, 32'h8000_5a00);
        // Clearing the bit ends sleep
        cfg_access(1'b1, 8'h40, 4'h8, 32'h0000_0000);
        @(negedge ref_clk_i);
        pwr_chk(pcip_pkg::PWR_RUN, 1'b0, 1'b0);
        // Snooze; the bench never sets both mode bits at once
        cfg_access(1'b1, 8'h40, 4'h8, 32'h4000_0000);
        repeat (8) @(negedge ref_clk_i);
        pwr_chk(pcip_pkg::PWR_DOZE, 1'b1, 1'b0);
        // Each wake source in turn: wake, hold, then re-gate
        for (int i = 0; i < 3; i++) begin
            {csr_access_i, tx_start_i, net_activity_i} = 3'b001 << i;
            @(negedge ref_clk_i);
            pwr_chk(pcip_pkg::PWR_WAKE, 1'b0, 1'b0);
            repeat (2) @(negedge ref_clk_i);
            {csr_access_i, tx_start_i, net_activity_i} = 3'b000;
            repeat (3) @(negedge ref_clk_i);
            pwr_chk(pcip_pkg::PWR_WAKE, 1'b0, 1'b0);
            repeat (5) @(negedge ref_clk_i);
            pwr_chk(pcip_pkg::PWR_DOZE, 1'b1, 1'b0);
        end
        // A host config access also wakes the block
        rd_chk(8'h40, 32'h4000_5a00);
        pwr_chk(pcip_pkg::PWR_WAKE, 1'b0, 1'b0);
        // Clearing snooze ends it for good
        cfg_access(1'b1, 8'h40, 4'h8, 32'h0000_0000);
        repeat (8) @(negedge ref_clk_i);
        pwr_chk(pcip_pkg::PWR_RUN, 1'b0, 1'b0);
        // Sleep again, then hardware reset ends it
        cfg_access(1'b1, 8'h40, 4'h8, 32'h8000_0000);
        @(negedge ref_clk_i);
        pwr_chk(pcip_pkg::PWR_SLEEP, 1'b1, 1'b1);
        reset_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        reset_i = 1'b0;
        pwr_chk(pcip_pkg::PWR_RUN, 1'b0, 1'b0);
        rd_chk(8'h40, 32'h0000_0000);
        rd_chk(8'h3c, 32'h2814_0100);
        summarize();
    end

endmodule : pcip_regs_tb

`default_nettype wire
